// ===== hdl/spindle_motor_servo_output.sv
// spindle motor output modulation, mode sequencing and apb registers
// Contract
// - four output modes chosen by register field
// - density drive, half duty means no actuation
// - second line inverse, changes on 1n MHz
// - two-line pwm accel/brake at 22.05n kHz
// - pin four config: four-line (needs pin five field zero too), subcode, low, high
// - pin five: de-emphasis, low, high, else four-line (needs pin four field zero too)
// - fifo position pwm on 300d Hz carrier
// - pll density at 4.23n MHz, servo off
// - twenty frame span, nominal gives 60 percent
// - anti-windup holds integrator when output saturates
// - start/stop drive limited 100/75/50/37 percent
// - eight loop gains, not scaled by n
// - two crossover settings scaled by n
// - play overflow resets fifo half, conceal loss
// - start one accelerates, pll reset
// - start two switches to jump at 75 percent
// - jump: servo on, fifo reset, hold, mute
// - second jump keeps integrator at zero
// - play entry resets fifo, releases mute
// - stop one brakes with negative drive
// - stop two at 12/6 percent flags, goes off
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module spindle_motor_servo_output #(
	parameter int FPOS_DIV = spindle_pkg::FPOS_DIV
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic signed [7:0]       servoDemand,
	input  wire logic [7:0]              discSpeedPct,
	input  wire logic signed [4:0]       fifoOffset,
	input  wire logic [7:0]              pllFreqLevel,
	input  wire logic                    fifoOverflow,
	input  wire logic                    subcodeData,
	input  wire logic                    deemphasisActive,
	output logic                         motorDriveA,
	output logic                         motorDriveB,
	output logic                         versatilePinFour,
	output logic                         versatilePinFive,
	output logic                         motorStoppedFlag,
	output spindle_pkg::servo_ctl_t      servoCtl,
	output spindle_pkg::loop_cfg_t       loopCfg
);
	spindle_pkg::opmode_t  opMode;
	spindle_pkg::opmode_t  prevMode;
	spindle_pkg::outmode_t outMode;
	logic                  antiWindup;
	logic [1:0]            powerLimit;
	logic                  brakeLow;
	logic [3:0]            pinSel;
	logic                  access;
	logic                  wrEn;
	logic [3:0]            regIdx;
	logic                  mapped;
	logic                  modeWrite;
	logic [31:0]           next_prdata;
	logic signed [7:0]     limit;
	logic signed [7:0]     drive;
	logic                  saturated;
	logic [7:0]            stopThr;
	logic [6:0]            pdDiv;
	logic                  pdTick;
	logic [7:0]            pdAcc;
	logic                  pdOut;
	logic [12:0]           pwmCnt;
	logic [12:0]           accelCmp;
	logic [12:0]           brakeCmp;
	logic [23:0]           fposCnt;
	logic [23:0]           fposCmp;
	logic [4:0]            pllDiv;
	logic [7:0]            pllAcc;
	logic                  pllOut;
	logic                  next_a;
	logic                  next_b;
	logic                  next_four;
	logic                  next_five;
	spindle_pkg::servo_ctl_t next_ctl;
	int                    fposFrames;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, unmapped index answers with an error
	assign access    = psel && penable && pready;
	assign wrEn      = access && pwrite;
	assign regIdx    = paddr[5:2];
	assign modeWrite = wrEn && mapped && regIdx == spindle_pkg::IDX_MODE;

	always_comb begin
		mapped      = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
		next_prdata = 32'h0;
		case (regIdx)
			spindle_pkg::IDX_MODE:   next_prdata = {28'h0, antiWindup, opMode};
			spindle_pkg::IDX_STATUS: next_prdata = {27'h0, saturated, opMode, motorStoppedFlag};
			spindle_pkg::IDX_LOOP4:  next_prdata = {27'h0, loopCfg.f4, loopCfg.gain};
			spindle_pkg::IDX_LOOP3:  next_prdata = {30'h0, loopCfg.f3};
			spindle_pkg::IDX_OUTCFG: next_prdata = {28'h0, powerLimit, outMode};
			spindle_pkg::IDX_PINSEL: next_prdata = 32'h0;
			spindle_pkg::IDX_BRAKE:  next_prdata = {31'h0, brakeLow};
			default:                 mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= (mapped && !pwrite) ? next_prdata : 32'h0;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			outMode    <= spindle_pkg::PDM2;
			powerLimit <= 2'h0;
			loopCfg    <= '0;
			pinSel     <= spindle_pkg::PINSEL_RESET;
			brakeLow   <= 1'b0;
			antiWindup <= 1'b0;
		end else if (wrEn && mapped) begin
			case (regIdx)
				spindle_pkg::IDX_OUTCFG: begin
					outMode    <= spindle_pkg::outmode_t'(pwdata[1:0]);
					powerLimit <= pwdata[spindle_pkg::OUT_LIMIT_LSB +: 2];
				end
				spindle_pkg::IDX_LOOP4: begin
					loopCfg.gain <= pwdata[2:0];
					loopCfg.f4   <= pwdata[spindle_pkg::LOOP4_F4_LSB +: 2];
				end
				spindle_pkg::IDX_LOOP3:  loopCfg.f3 <= pwdata[1:0];
				spindle_pkg::IDX_PINSEL: pinSel <= pwdata[3:0];
				spindle_pkg::IDX_BRAKE:  brakeLow <= pwdata[0];
				spindle_pkg::IDX_MODE:   antiWindup <= pwdata[spindle_pkg::MODE_AW_BIT];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operating mode sequencer; a software write wins over a speed decision
	assign stopThr = brakeLow ? spindle_pkg::STOP_PCT_LO : spindle_pkg::STOP_PCT_HI;

	always_ff @(posedge clk) begin
		if (rst) begin
			opMode <= spindle_pkg::OFF;
		end else if (modeWrite) begin
			opMode <= spindle_pkg::opmode_t'(pwdata[2:0]);
		end else begin
			case (opMode)
				spindle_pkg::START2: begin
					if (discSpeedPct >= spindle_pkg::START_SWITCH_PCT) begin
						opMode <= spindle_pkg::JUMP;
					end
				end
				spindle_pkg::STOP2: begin
					if (discSpeedPct <= stopThr) begin
						opMode <= spindle_pkg::OFF;
					end
				end
				default: opMode <= opMode;
			endcase
		end
	end

	// stopped flag: a mode register write clears it, a stop detection in the same cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			motorStoppedFlag <= 1'b0;
		end else if (opMode == spindle_pkg::STOP2 && discSpeedPct <= stopThr) begin
			motorStoppedFlag <= 1'b1;
		end else if (modeWrite) begin
			motorStoppedFlag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prevMode <= spindle_pkg::OFF;
		end else begin
			prevMode <= opMode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// servo control lines
	assign saturated = servoDemand == 8'sh7F || servoDemand == 8'sh80;

	always_comb begin
		next_ctl             = '0;
		next_ctl.audioMute   = opMode != spindle_pkg::PLAY;
		next_ctl.pllReset    = opMode == spindle_pkg::START1;
		case (opMode)
			spindle_pkg::JUMP, spindle_pkg::JUMP2: begin
				next_ctl.servoEnable    = 1'b1;
				next_ctl.fifoResetHalf  = 1'b1;
				next_ctl.integratorHold = 1'b1;
				next_ctl.integratorZero = opMode == spindle_pkg::JUMP2;
			end
			spindle_pkg::PLAY: begin
				next_ctl.servoEnable    = 1'b1;
				next_ctl.integratorHold = antiWindup && saturated;
				next_ctl.fifoResetHalf  = prevMode != spindle_pkg::PLAY || fifoOverflow;
				next_ctl.concealLoss    = prevMode == spindle_pkg::PLAY && fifoOverflow;
			end
			default: begin
			end
		endcase
		if (outMode == spindle_pkg::FIFOPOS) begin
			next_ctl.servoEnable = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			servoCtl <= '0;
		end else begin
			servoCtl <= next_ctl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// drive demand
	always_comb begin
		case (powerLimit)
			2'h0:    limit = spindle_pkg::LIM_100;
			2'h1:    limit = spindle_pkg::LIM_75;
			2'h2:    limit = spindle_pkg::LIM_50;
			default: limit = spindle_pkg::LIM_37;
		endcase
		case (opMode)
			spindle_pkg::START1, spindle_pkg::START2: drive = limit;
			spindle_pkg::STOP1, spindle_pkg::STOP2:   drive = -limit;
			spindle_pkg::OFF:                         drive = 8'sh00;
			default:                                  drive = servoDemand;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// modulators
	assign pdTick = pdDiv == 7'(spindle_pkg::PD_DIV - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			pdDiv <= 7'h00;
			pdAcc <= 8'h00;
			pdOut <= 1'b0;
		end else begin
			pdDiv <= pdTick ? 7'h00 : pdDiv + 7'h01;
			if (pdTick) begin
				// offset binary: zero drive gives half density
				{pdOut, pdAcc} <= {1'b0, pdAcc} + {1'b0, drive ^ 8'h80};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwmCnt <= 13'h0000;
		end else begin
			pwmCnt <= (pwmCnt == 13'(spindle_pkg::PWM_DIV - 1)) ? 13'h0000 : pwmCnt + 13'h0001;
		end
	end

	always_comb begin
		accelCmp = 13'h0000;
		brakeCmp = 13'h0000;
		if (drive > 8'sh00) begin
			accelCmp = 13'((int'(drive) * spindle_pkg::PWM_DIV) / 127);
		end else if (drive < 8'sh00) begin
			brakeCmp = 13'((-int'(drive) * spindle_pkg::PWM_DIV) / 127);
		end
	end

	always_comb begin
		fposFrames = spindle_pkg::FIFO_NOM_FRAMES + int'(fifoOffset);
		if (fposFrames < 0) begin
			fposFrames = 0;
		end else if (fposFrames > spindle_pkg::FIFO_SPAN) begin
			fposFrames = spindle_pkg::FIFO_SPAN;
		end
		fposCmp = 24'((fposFrames * FPOS_DIV) / spindle_pkg::FIFO_SPAN);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fposCnt <= 24'h000000;
			pllDiv  <= 5'h00;
			pllAcc  <= 8'h00;
			pllOut  <= 1'b0;
		end else begin
			fposCnt <= (fposCnt == 24'(FPOS_DIV - 1)) ? 24'h000000 : fposCnt + 24'h000001;
			pllDiv  <= (pllDiv == 5'(spindle_pkg::PLLPD_DIV - 1)) ? 5'h00 : pllDiv + 5'h01;
			if (pllDiv == 5'(spindle_pkg::PLLPD_DIV - 1)) begin
				{pllOut, pllAcc} <= {1'b0, pllAcc} + {1'b0, pllFreqLevel};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output selection
	always_comb begin
		next_a    = 1'b0;
		next_b    = 1'b0;
		next_four = 1'b0;
		next_five = 1'b0;
		case (outMode)
			spindle_pkg::PDM2: begin
				next_a = pdOut;
				next_b = !pdOut;
			end
			spindle_pkg::PWM2, spindle_pkg::PWM4: begin
				next_a = pwmCnt < accelCmp;
				next_b = pwmCnt < brakeCmp;
				next_four = drive > 8'sh00;
				next_five = drive < 8'sh00;
			end
			spindle_pkg::FIFOPOS: begin
				next_a = fposCnt < fposCmp;
				next_b = pllOut;
			end
			default: begin
			end
		endcase
		if (opMode == spindle_pkg::OFF && outMode != spindle_pkg::FIFOPOS) begin
			next_a    = 1'b0;
			next_b    = 1'b0;
			next_four = 1'b0;
			next_five = 1'b0;
		end
		if (!(pinSel == 4'h0 && outMode == spindle_pkg::PWM4)) begin
			next_four = 1'b0;
		end
		if (!(pinSel == 4'h0 && outMode == spindle_pkg::PWM4)) begin
			next_five = 1'b0;
		end
		case (pinSel[1:0])
			2'h1:    next_four = subcodeData;
			2'h2:    next_four = 1'b0;
			2'h3:    next_four = 1'b1;
			default: begin
			end
		endcase
		case (pinSel[3:2])
			2'h1:    next_five = deemphasisActive;
			2'h2:    next_five = 1'b0;
			2'h3:    next_five = 1'b1;
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			motorDriveA      <= 1'b0;
			motorDriveB      <= 1'b0;
			versatilePinFour <= 1'b0;
			versatilePinFive <= 1'b0;
		end else begin
			motorDriveA      <= next_a;
			motorDriveB      <= next_b;
			versatilePinFour <= next_four;
			versatilePinFive <= next_five;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_pdm_inverse;
		@(posedge clk) disable iff (rst)
		$past(outMode == spindle_pkg::PDM2 && opMode != spindle_pkg::OFF) |->
			motorDriveB == !motorDriveA;
	endproperty
	a_pdm_inverse: assert property (p_pdm_inverse) else $error("density lines not inverse");

	property p_pdm_tick;
		@(posedge clk) disable iff (rst)
		($past(outMode == spindle_pkg::PDM2 && opMode != spindle_pkg::OFF, 1) &&
			$past(outMode == spindle_pkg::PDM2 && opMode != spindle_pkg::OFF, 2) &&
			!$past(pdTick, 2)) |-> $stable(motorDriveA);
	endproperty
	a_pdm_tick: assert property (p_pdm_tick) else $error("density line moved off tick");

	property p_start_jump;
		@(posedge clk) disable iff (rst)
		(opMode == spindle_pkg::START2 && discSpeedPct >= spindle_pkg::START_SWITCH_PCT &&
			!modeWrite) |=> opMode == spindle_pkg::JUMP;
	endproperty
	a_start_jump: assert property (p_start_jump) else $error("no switch to jump");

	property p_stop_off;
		@(posedge clk) disable iff (rst)
		(opMode == spindle_pkg::STOP2 && discSpeedPct <= stopThr && !modeWrite) |=>
			(opMode == spindle_pkg::OFF && motorStoppedFlag) ##1 (!motorDriveA || outMode == spindle_pkg::FIFOPOS);
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop detection missed");

	property p_play_entry;
		@(posedge clk) disable iff (rst)
		(opMode == spindle_pkg::PLAY && prevMode != spindle_pkg::PLAY) |=>
			servoCtl.fifoResetHalf && !servoCtl.audioMute;
	endproperty
	a_play_entry: assert property (p_play_entry) else $error("play entry without fifo reset");

	property p_jump_ctl;
		@(posedge clk) disable iff (rst)
		opMode == spindle_pkg::JUMP |=>
			servoCtl.fifoResetHalf && servoCtl.integratorHold && servoCtl.audioMute;
	endproperty
	a_jump_ctl: assert property (p_jump_ctl) else $error("jump controls wrong");

	property p_jump2_zero;
		@(posedge clk) disable iff (rst)
		opMode == spindle_pkg::JUMP2 |=> servoCtl.integratorZero;
	endproperty
	a_jump2_zero: assert property (p_jump2_zero) else $error("integrator not zeroed");

	property p_overflow;
		@(posedge clk) disable iff (rst)
		(opMode == spindle_pkg::PLAY && prevMode == spindle_pkg::PLAY && fifoOverflow) |=>
			servoCtl.fifoResetHalf && servoCtl.concealLoss;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not recovered");

	property p_antiwindup;
		@(posedge clk) disable iff (rst)
		(opMode == spindle_pkg::PLAY && antiWindup && saturated) |=> servoCtl.integratorHold;
	endproperty
	a_antiwindup: assert property (p_antiwindup) else $error("integrator not held");

	property p_fpos_servo_off;
		@(posedge clk) disable iff (rst)
		outMode == spindle_pkg::FIFOPOS |=> !servoCtl.servoEnable;
	endproperty
	a_fpos_servo_off: assert property (p_fpos_servo_off) else $error("servo left enabled");

	property p_start1_pll;
		@(posedge clk) disable iff (rst)
		opMode == spindle_pkg::START1 |=> servoCtl.pllReset;
	endproperty
	a_start1_pll: assert property (p_start1_pll) else $error("pll not reset");
endmodule

// ===== hdl/spindle_pkg.sv
// constants, types and register map of the spindle motor output block
package spindle_pkg;
	localparam int CLK_HZ          = 100_000_000;
	localparam int OVERSPEED       = 1;
	localparam int DISC_FACTOR     = 1;
	localparam int PD_RATE_HZ      = 1_000_000;
	localparam int PD_DIV          = CLK_HZ / (PD_RATE_HZ * OVERSPEED);
	localparam int PWM_RATE_HZ     = 22_050;
	localparam int PWM_DIV         = CLK_HZ / (PWM_RATE_HZ * OVERSPEED);
	localparam int PLLPD_RATE_KHZ  = 4_230;
	localparam int PLLPD_DIV       = CLK_HZ / (PLLPD_RATE_KHZ * 1000 * OVERSPEED);
	localparam int FPOS_RATE_HZ    = 300;
	localparam int FPOS_DIV        = CLK_HZ / (FPOS_RATE_HZ * DISC_FACTOR);
	localparam int FIFO_SPAN       = 20;
	localparam int FIFO_NOM_PCT    = 60;
	localparam int FIFO_NOM_FRAMES = FIFO_SPAN * FIFO_NOM_PCT / 100;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_MODE   = 4'h1;
	localparam logic [3:0] IDX_STATUS = 4'h2;
	localparam logic [3:0] IDX_LOOP4  = 4'h4;
	localparam logic [3:0] IDX_LOOP3  = 4'h5;
	localparam logic [3:0] IDX_OUTCFG = 4'h6;
	localparam logic [3:0] IDX_PINSEL = 4'hD;
	localparam logic [3:0] IDX_BRAKE  = 4'hE;
	localparam int MODE_AW_BIT     = 3;
	localparam int OUT_LIMIT_LSB   = 2;
	localparam int LOOP4_F4_LSB    = 3;
	localparam int ST_MODE_LSB     = 1;
	localparam int ST_SAT_BIT      = 4;
	localparam logic [3:0] PINSEL_RESET = 4'h2;
	localparam logic signed [7:0] LIM_100 = 8'sh7F;
	localparam logic signed [7:0] LIM_75  = 8'sh5F;
	localparam logic signed [7:0] LIM_50  = 8'sh3F;
	localparam logic signed [7:0] LIM_37  = 8'sh2F;
	localparam logic [7:0] START_SWITCH_PCT = 8'h4B;
	localparam logic [7:0] STOP_PCT_HI      = 8'h0C;
	localparam logic [7:0] STOP_PCT_LO      = 8'h06;
	typedef enum logic [2:0] {START1, START2, JUMP, JUMP2, PLAY, STOP1, STOP2, OFF} opmode_t;
	typedef enum logic [1:0] {PDM2, PWM2, PWM4, FIFOPOS} outmode_t;
	typedef struct packed {
		logic servoEnable;
		logic integratorHold;
		logic integratorZero;
		logic pllReset;
		logic fifoResetHalf;
		logic audioMute;
		logic concealLoss;
	} servo_ctl_t;
	typedef struct packed {
		logic [2:0] gain;
		logic [1:0] f4;
		logic [1:0] f3;
	} loop_cfg_t;
endpackage

// ===== verif/motor_bridge_model.sv
// motor bridge stand-in: counts how long each drive line is high
`timescale 1ns/100ps
module motor_bridge_model (
	input  wire logic clk,
	input  wire logic clr,
	input  wire logic lineA,
	input  wire logic lineB,
	input  wire logic lineC,
	input  wire logic lineD,
	output int        aHigh,
	output int        bHigh,
	output int        cHigh,
	output int        dHigh,
	output int        sameCnt,
	output int        oddGap
);
	int   gap;
	logic prevA;
	logic first;
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		prevA <= lineA;
		if (clr) begin
			aHigh <= 0;
			bHigh <= 0;
			cHigh <= 0;
			dHigh <= 0;
			sameCnt <= 0;
			oddGap <= 0;
			gap <= 0;
			first <= 1'b1;
		end else begin
			aHigh <= aHigh + int'(lineA);
			bHigh <= bHigh + int'(lineB);
			cHigh <= cHigh + int'(lineC);
			dHigh <= dHigh + int'(lineD);
			sameCnt <= sameCnt + int'(lineA == lineB);
			// spacing between line A changes, first change after clear is not measured
			if (lineA != prevA) begin
				if (!first && (gap % 100) != 0)
					oddGap <= oddGap + 1;
				first <= 1'b0;
				gap <= 1;
			end else
				gap <= gap + 1;
		end
	end
endmodule

// ===== verif/spindle_motor_servo_output_test.sv
// self-checking bench for the spindle motor output block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failCount++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module spindle_motor_servo_output_test;
	localparam logic [7:0] AMODE = {2'b00, spindle_pkg::IDX_MODE, 2'b00};
	localparam logic [7:0] ASTAT = {2'b00, spindle_pkg::IDX_STATUS, 2'b00};
	localparam logic [7:0] AOUT  = {2'b00, spindle_pkg::IDX_OUTCFG, 2'b00};
	localparam logic [7:0] APIN  = {2'b00, spindle_pkg::IDX_PINSEL, 2'b00};
	localparam logic [7:0] ABRK  = {2'b00, spindle_pkg::IDX_BRAKE, 2'b00};
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} regrow_t;
	typedef struct {logic [3:0] sel; logic sub; logic de; logic e4; logic e5;} pinrow_t;
	typedef struct {spindle_pkg::opmode_t m; logic [31:0] cfg; logic brk; int lo; int hi;} pwmrow_t;
	logic                    clk, rst, psel, penable, pwrite, pready, pslverr, er, clr;
	logic [7:0]              paddr, discSpeedPct, pllFreqLevel;
	logic [31:0]             pwdata, prdata, rd;
	logic signed [7:0]       servoDemand;
	logic signed [4:0]       fifoOffset;
	logic                    fifoOverflow, subcodeData, deemphasisActive, seenR, seenC;
	logic                    motorDriveA, motorDriveB, versatilePinFour, versatilePinFive;
	logic                    motorStoppedFlag;
	spindle_pkg::servo_ctl_t servoCtl;
	spindle_pkg::loop_cfg_t  loopCfg;
	int                      failCount, numChecks, aHigh, bHigh, cHigh, dHigh, sameCnt, oddGap;
	int                      hiCnt, loCnt;
	regrow_t regs[8] = '{'{AMODE, 32'h0000000C, 32'h0000000C, 1'b0},
		'{8'h10, 32'hFFFFFF1F, 32'h0000001F, 1'b0}, '{8'h14, 32'h00000002, 32'h00000002, 1'b0},
		'{AOUT, 32'h0000000D, 32'h0000000D, 1'b0}, '{APIN, 32'h00000003, 32'h00000000, 1'b0},
		'{ABRK, 32'h00000001, 32'h00000001, 1'b0}, '{8'h3C, 32'h00000005, 32'h00000000, 1'b1},
		'{8'h46, 32'h00000005, 32'h00000000, 1'b1}};
	pinrow_t pins[8] = '{'{4'h3, 0, 0, 1, 0}, '{4'h2, 1, 1, 0, 0}, '{4'h1, 1, 0, 1, 0},
		'{4'h1, 0, 0, 0, 0}, '{4'h7, 0, 1, 1, 1}, '{4'h7, 0, 0, 1, 0}, '{4'hB, 0, 1, 1, 0},
		'{4'hF, 0, 0, 1, 1}};
	pwmrow_t pw[5] = '{'{spindle_pkg::START1, 32'h1, 0, 4400, 4535},
		'{spindle_pkg::START1, 32'h5, 0, 3200, 3550}, '{spindle_pkg::START1, 32'hE, 0, 1500, 1900},
		'{spindle_pkg::STOP1, 32'h9, 1, 2100, 2500}, '{spindle_pkg::STOP1, 32'hD, 1, 1500, 1900}};

	spindle_motor_servo_output #(.FPOS_DIV(200)) u_dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .servoDemand(servoDemand),
		.discSpeedPct(discSpeedPct), .fifoOffset(fifoOffset), .pllFreqLevel(pllFreqLevel),
		.fifoOverflow(fifoOverflow), .subcodeData(subcodeData),
		.deemphasisActive(deemphasisActive), .motorDriveA(motorDriveA),
		.motorDriveB(motorDriveB), .versatilePinFour(versatilePinFour),
		.versatilePinFive(versatilePinFive), .motorStoppedFlag(motorStoppedFlag),
		.servoCtl(servoCtl), .loopCfg(loopCfg));
	motor_bridge_model u_bridge (.clk(clk), .clr(clr), .lineA(motorDriveA),
		.lineB(motorDriveB), .lineC(versatilePinFour), .lineD(versatilePinFive),
		.aHigh(aHigh), .bHigh(bHigh), .cHigh(cHigh), .dHigh(dHigh), .sameCnt(sameCnt),
		.oddGap(oddGap));

	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			`CHK("pready", 1'b1, 1'b0)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	task automatic modeIs(input spindle_pkg::opmode_t m, input logic f = 1'b0);
		rdchk("opMode", ASTAT, {28'h0, m, f});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic measure(input int n);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		settle(n);
	endtask
	task automatic resetChecks;
		settle(2);
		`CHK("loopCfg", 7'h00, loopCfg)
		`CHK("stopFlag", 1'b0, motorStoppedFlag)
		`CHK("mute", 1'b1, servoCtl.audioMute)
		rdchk("mode", AMODE, 32'h7);
		rdchk("status", ASTAT, 32'hE);
		rdchk("outCfg", AOUT, 32'h0);
		rdchk("brake", ABRK, 32'h0);
	endtask
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#600_000;
		failCount++;
		endOfTest();
	end
	initial begin
		{clk, rst, psel, penable, pwrite, clr, fifoOverflow, subcodeData} = 8'h40;
		{paddr, pwdata, servoDemand, fifoOffset, pllFreqLevel, deemphasisActive} = '0;
		{failCount, numChecks} = '0;
		discSpeedPct = 8'd50;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		resetChecks();
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			`CHK("wrErr", regs[i].err, er)
			apb(1'b0, regs[i].a, 32'h0);
			`CHK("rdErr", regs[i].err, er)
			`CHK("rdData", regs[i].e, rd)
		end
		`CHK("loopCfg", 7'h7E, loopCfg)
		foreach (pins[i]) begin
			wr(APIN, {28'h0, pins[i].sel});
			subcodeData <= pins[i].sub;
			deemphasisActive <= pins[i].de;
			settle(3);
			`CHK("pinFour", pins[i].e4, versatilePinFour)
			`CHK("pinFive", pins[i].e5, versatilePinFive)
		end
		wr(AMODE, 32'h1);
		discSpeedPct <= 8'd74;
		settle(3);
		modeIs(spindle_pkg::START2);
		discSpeedPct <= 8'd75;
		settle(3);
		modeIs(spindle_pkg::JUMP);
		`CHK("jumpCtl", 7'b1100110, servoCtl)
		wr(AMODE, 32'h3);
		settle(2);
		`CHK("zeroInt", 1'b1, servoCtl.integratorZero & servoCtl.servoEnable)
		wr(AMODE, 32'h4);
		settle(1);
		`CHK("entryReset", 2'b10, {servoCtl.fifoResetHalf, servoCtl.audioMute})
		settle(1);
		`CHK("released", 1'b0, servoCtl.fifoResetHalf)
		@(posedge clk);
		fifoOverflow <= 1'b1;
		@(posedge clk);
		fifoOverflow <= 1'b0;
		{seenR, seenC} = 2'b00;
		repeat (3) begin
			#1;
			seenR |= servoCtl.fifoResetHalf;
			seenC |= servoCtl.concealLoss;
			@(posedge clk);
		end
		`CHK("overflow", 2'b11, {seenR, seenC})
		wr(AMODE, 32'hC);
		servoDemand <= 8'sd127;
		settle(3);
		`CHK("awHold", 1'b1, servoCtl.integratorHold)
		rdchk("satStatus", ASTAT, 32'h18);
		servoDemand <= 8'sd10;
		settle(3);
		`CHK("awFree", 1'b0, servoCtl.integratorHold)
		wr(AOUT, 32'h0);
		servoDemand <= 8'sd0;
		settle(4);
		measure(2000);
		`CHK("halfDuty", 1'b1, aHigh > 900 && aHigh < 1100)
		`CHK("inverse", 0, sameCnt)
		`CHK("tickEdges", 0, oddGap)
		wr(APIN, 32'h0);
		foreach (pw[i]) begin
			wr(AOUT, pw[i].cfg);
			wr(AMODE, {29'h0, pw[i].m});
			settle(4);
			if (pw[i].m == spindle_pkg::START1)
				`CHK("pllReset", 1'b1, servoCtl.pllReset)
			measure(4535);
			hiCnt = pw[i].brk ? bHigh : aHigh;
			loCnt = pw[i].brk ? aHigh : bHigh;
			`CHK("driveDuty", 1'b1, hiCnt >= pw[i].lo && hiCnt <= pw[i].hi)
			`CHK("idleLine", 0, loCnt)
			if (pw[i].cfg[1:0] == 2'd2)
				`CHK("fwdLeg", 1'b1, cHigh > 0 && dHigh == 0)
		end
		// controller in lock-to-disc operation picks the fifo-position output
		wr(AOUT, 32'h3);
		wr(AMODE, 32'h4);
		fifoOffset <= 5'sd0;
		pllFreqLevel <= 8'h80;
		settle(4);
		measure(2000);
		`CHK("fposDuty", 1'b1, aHigh >= 1180 && aHigh <= 1220)
		`CHK("pllDensity", 1'b1, bHigh > 800 && bHigh < 1200)
		`CHK("servoOff", 1'b0, servoCtl.servoEnable)
		@(posedge clk);
		fifoOffset <= 5'sd8;
		measure(2000);
		`CHK("fposFull", 1'b1, aHigh >= 1980)
		wr(AOUT, 32'h1);
		wr(ABRK, 32'h0);
		wr(AMODE, 32'h6);
		discSpeedPct <= 8'd13;
		settle(3);
		modeIs(spindle_pkg::STOP2);
		discSpeedPct <= 8'd12;
		settle(3);
		`CHK("stopFlag", 1'b1, motorStoppedFlag)
		`CHK("undriven", 2'b00, {motorDriveA, motorDriveB})
		modeIs(spindle_pkg::OFF, 1'b1);
		wr(ABRK, 32'h1);
		wr(AMODE, 32'h6);
		settle(3);
		`CHK("lowBrake", 1'b0, motorStoppedFlag)
		discSpeedPct <= 8'd6;
		settle(3);
		`CHK("lowStop", 1'b1, motorStoppedFlag)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		resetChecks();
		endOfTest();
	end
endmodule
